// ==== core/wct_pkg.sv ====
// constants, types and helpers shared by the weekly cycle timer scheduler
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
package wct_pkg;

    // ------------------------------------------------------------------
    // sizes and time figures
    // ------------------------------------------------------------------
    localparam int NUM_TIMERS = 7;
    localparam int NUM_DAYS = 7;
    localparam int NUM_OUTS = 2;
    localparam int DAY_W = 3;
    localparam int MIN_W = 11;
    localparam int HR_W = 5;
    localparam int MN_W = 6;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam logic [DAY_W-1:0] DAYS_PER_WEEK = 3'h7;
    localparam logic [HR_W-1:0] HOURS_PER_DAY = 5'h18;
    localparam logic [MIN_W-1:0] MIN_PER_HOUR = 11'h03c;
    localparam logic [MIN_W-1:0] MIN_PER_DAY = 11'h5a0;
    localparam logic [MIN_W-1:0] DUR_MAX_MIN = 11'h5a0;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_TIMER0 = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h020;
    localparam logic [ADDR_W-1:0] OFS_STAT = 12'h024;
    localparam logic [ADDR_W-1:0] OFS_CODES = 12'h028;
    localparam logic [ADDR_W-1:0] OFS_TIME = 12'h02c;
    localparam int WORD_SHIFT = 2;

    // timer word fields
    localparam int F_DAYS = 0;
    localparam int F_OUT1 = 7;
    localparam int F_OUT2 = 8;
    localparam int F_SHR = 9;
    localparam int F_SMN = 14;
    localparam int F_DHR = 20;
    localparam int F_DMN = 25;
    // control word fields
    localparam int F_RUN_MAP = 0;
    localparam int F_DISC_MAP = 1;
    // status word fields
    localparam int F_ST_ACT = 0;
    localparam int F_ST_OUT1 = 8;
    localparam int F_ST_OUT2 = 9;
    // time word fields
    localparam int F_T_MIN = 0;
    localparam int F_T_DAY = 16;

    localparam logic [DATA_W-1:0] TIMER_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0001;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CODE_IDLE = 2'h0,
        CODE_ON = 2'h1,
        CODE_DASH = 2'h2
    } wct_code_e;

    typedef struct packed {
        logic [NUM_DAYS-1:0] day_en;
        logic out1_en;
        logic out2_en;
        logic [HR_W-1:0] start_hr;
        logic [MN_W-1:0] start_mn;
        logic [HR_W-1:0] dur_hr;
        logic [MN_W-1:0] dur_mn;
    } wct_cfg_s;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
        logic [STRB_W-1:0] pstrb;
    } wct_apb_req_s;

    // unpack a timer register word
    function automatic wct_cfg_s cfg_of(input logic [DATA_W-1:0] w);
        wct_cfg_s c;
        c.day_en = w[F_DAYS +: NUM_DAYS];
        c.out1_en = w[F_OUT1];
        c.out2_en = w[F_OUT2];
        c.start_hr = w[F_SHR +: HR_W];
        c.start_mn = w[F_SMN +: MN_W];
        c.dur_hr = w[F_DHR +: HR_W];
        c.dur_mn = w[F_DMN +: MN_W];
        return c;
    endfunction

endpackage

// ==== core/wct_timer.sv ====
// one scheduling timer of the weekly cycle timer scheduler
`timescale 1ns/1ps
module wct_timer (
    input wire logic clk,
    input wire logic arst_n,
    input wct_pkg::wct_cfg_s cfg,
    input wire logic [wct_pkg::DAY_W-1:0] weekday,
    input wire logic [wct_pkg::MIN_W-1:0] minute_now,
    input wire logic minute_tick,
    output logic active,
    output logic [wct_pkg::NUM_OUTS-1:0] req,
    output logic [2*wct_pkg::NUM_OUTS-1:0] codes
);
    logic [wct_pkg::MIN_W-1:0] rem_q, rem_d;
    logic [wct_pkg::MIN_W-1:0] start_min, dur_raw, dur_min;
    logic [wct_pkg::NUM_OUTS-1:0] req_q, req_d, en;
    logic [2*wct_pkg::NUM_OUTS-1:0] codes_q, codes_d;
    logic start_hit;

    // ------------------------------------------------------------------
    // setpoint arithmetic
    // ------------------------------------------------------------------
    always_comb begin
        start_min = wct_pkg::MIN_W'(cfg.start_hr) * wct_pkg::MIN_PER_HOUR
                  + wct_pkg::MIN_W'(cfg.start_mn);
        dur_raw = wct_pkg::MIN_W'(cfg.dur_hr) * wct_pkg::MIN_PER_HOUR
                + wct_pkg::MIN_W'(cfg.dur_mn);
        // clamp duration to one full day
        dur_min = (dur_raw > wct_pkg::DUR_MAX_MIN) ?
                  wct_pkg::DUR_MAX_MIN : dur_raw;
        start_hit = minute_tick && (weekday < wct_pkg::DAYS_PER_WEEK)
                  && cfg.day_en[weekday]
                  && (cfg.start_hr < wct_pkg::HOURS_PER_DAY)
                  && (minute_now == start_min)
                  && (dur_min != '0);
    end

    // ------------------------------------------------------------------
    // remaining-minute counter and outputs
    // ------------------------------------------------------------------
    always_comb begin
        rem_d = rem_q;
        // keeps counting across midnight whatever the day enables
        if (minute_tick && rem_q != '0) begin
            rem_d = rem_q - 1'b1;
        end
        if (start_hit) begin
            rem_d = dur_min;
        end
        en = {cfg.out2_en, cfg.out1_en};
        for (int o = 0; o < wct_pkg::NUM_OUTS; o++) begin
            req_d[o] = en[o] && (rem_d != '0);
            if (!en[o]) begin
                codes_d[2*o +: 2] = wct_pkg::CODE_DASH;
            end else if (req_d[o]) begin
                codes_d[2*o +: 2] = wct_pkg::CODE_ON;
            end else begin
                codes_d[2*o +: 2] = wct_pkg::CODE_IDLE;
            end
        end
    end

    // register state
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rem_q <= '0;
            req_q <= '0;
            codes_q <= {wct_pkg::NUM_OUTS{wct_pkg::CODE_DASH}};
        end else begin
            rem_q <= rem_d;
            req_q <= req_d;
            codes_q <= codes_d;
        end
    end

    assign active = (rem_q != '0);
    assign req = req_q;
    assign codes = codes_q;
endmodule

// ==== core/wct_top.sv ====
// weekly cycle timer scheduler: seven timers, apb registers, routing
`timescale 1ns/1ps
module wct_top (
    input wire logic clk,
    input wire logic arst_n,
    // apb slave
    input wct_pkg::wct_apb_req_s apb_req,
    output logic pready,
    output logic [wct_pkg::DATA_W-1:0] prdata,
    output logic pslverr,
    // weekday and minute of day from the real-time clock
    input wire logic [wct_pkg::DAY_W-1:0] rtc_weekday,
    input wire logic [wct_pkg::MIN_W-1:0] rtc_minute,
    // combined schedule outputs
    output logic run_request_output,
    output logic aux_request_output,
    // routed outputs and per-timer activity
    output logic remote_run_req,
    output logic discrete_out,
    output logic [wct_pkg::NUM_TIMERS-1:0] timer_active
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    localparam int NT = wct_pkg::NUM_TIMERS;
    localparam int CODE_W = 2 * wct_pkg::NUM_OUTS;

    // kind of register an address selects
    typedef enum logic [5:0] {
        REG_NONE = 6'h01,
        REG_TIMER = 6'h02,
        REG_CTRL = 6'h04,
        REG_STAT = 6'h08,
        REG_CODES = 6'h10,
        REG_TIME = 6'h20
    } wct_reg_e;

    logic [wct_pkg::DATA_W-1:0] tmr_q [NT];
    logic [wct_pkg::DATA_W-1:0] tmr_d [NT];
    logic [wct_pkg::DATA_W-1:0] ctrl_q, ctrl_d;
    logic [wct_pkg::DATA_W-1:0] prdata_q, prdata_d;
    logic pslverr_q, pslverr_d;
    logic [wct_pkg::MIN_W-1:0] last_min_q, last_min_d;
    logic tick_armed_q, tick_armed_d;
    logic minute_tick;
    logic out1_q, out1_d, out2_q, out2_d;
    logic run_q, run_d, disc_q, disc_d;
    logic [NT-1:0] act;
    logic [NT-1:0] req1, req2;
    logic [CODE_W*NT-1:0] all_codes;
    logic setup, wr_setup;
    logic [wct_pkg::DATA_W-1:0] stat_w, codes_w, time_w;
    wct_reg_e acc_kind;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------

    // index of the timer word addressed, or NT when none
    function automatic int timer_idx(
        input logic [wct_pkg::ADDR_W-1:0] a
    );
        int idx;
        idx = NT;
        for (int i = 0; i < NT; i++) begin
            if (a == wct_pkg::OFS_TIMER0
                     + wct_pkg::ADDR_W'(i << wct_pkg::WORD_SHIFT)) begin
                idx = i;
            end
        end
        return idx;
    endfunction

    // byte-lane merge of write data into an old word
    function automatic logic [wct_pkg::DATA_W-1:0] merge(
        input logic [wct_pkg::DATA_W-1:0] old,
        input logic [wct_pkg::DATA_W-1:0] wd,
        input logic [wct_pkg::STRB_W-1:0] strb
    );
        logic [wct_pkg::DATA_W-1:0] r;
        r = old;
        for (int b = 0; b < wct_pkg::STRB_W; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return r;
    endfunction

    // which register an address selects; timer words share one kind
    function automatic wct_reg_e reg_of(
        input logic [wct_pkg::ADDR_W-1:0] a
    );
        wct_reg_e k;
        if (timer_idx(a) < NT) begin
            k = REG_TIMER;
        end else if (a == wct_pkg::OFS_CTRL) begin
            k = REG_CTRL;
        end else if (a == wct_pkg::OFS_STAT) begin
            k = REG_STAT;
        end else if (a == wct_pkg::OFS_CODES) begin
            k = REG_CODES;
        end else if (a == wct_pkg::OFS_TIME) begin
            k = REG_TIME;
        end else begin
            k = REG_NONE;
        end
        return k;
    endfunction

    // ------------------------------------------------------------------
    // minute change detect
    // ------------------------------------------------------------------

    // a new minute value from the clock starts one evaluation
    always_comb begin
        tick_armed_d = 1'b1;
        last_min_d = rtc_minute;
        minute_tick = (rtc_minute < wct_pkg::MIN_PER_DAY)
                    && (!tick_armed_q || rtc_minute != last_min_q);
    end

    // first cycle after reset counts as a tick if the minute is below MIN_PER_DAY
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            last_min_q <= '0;
            tick_armed_q <= 1'b0;
        end else begin
            last_min_q <= last_min_d;
            tick_armed_q <= tick_armed_d;
        end
    end

    // ------------------------------------------------------------------
    // timers
    // ------------------------------------------------------------------

    // seven independent timers, each on its own register word
    generate
        for (genvar g = 0; g < NT; g++) begin : g_tmr
            wct_timer u_tmr (
                .clk(clk),
                .arst_n(arst_n),
                .cfg(wct_pkg::cfg_of(tmr_q[g])),
                .weekday(rtc_weekday),
                .minute_now(rtc_minute),
                .minute_tick(minute_tick),
                .active(act[g]),
                .req({req2[g], req1[g]}),
                .codes(all_codes[CODE_W*g +: CODE_W])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // combining and routing
    // ------------------------------------------------------------------

    // any timer drives each combined output
    always_comb begin
        out1_d = |req1;
        out2_d = |req2;
        run_d = out1_d && ctrl_q[wct_pkg::F_RUN_MAP];
        disc_d = out2_d && ctrl_q[wct_pkg::F_DISC_MAP];
    end

    // combined and routed outputs both leave from flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out1_q <= 1'b0;
            out2_q <= 1'b0;
            run_q <= 1'b0;
            disc_q <= 1'b0;
        end else begin
            out1_q <= out1_d;
            out2_q <= out2_d;
            run_q <= run_d;
            disc_q <= disc_d;
        end
    end

    assign run_request_output = out1_q;
    assign aux_request_output = out2_q;
    assign remote_run_req = run_q;
    assign discrete_out = disc_q;
    assign timer_active = act;

    // ------------------------------------------------------------------
    // apb register writes
    // ------------------------------------------------------------------

    // reads are decoded in the setup cycle, writes in the access cycle; write takes effect
    // at the access edge, which is always the one that ends it
    assign setup = apb_req.psel && !apb_req.penable;
    assign wr_setup = apb_req.psel && apb_req.penable && apb_req.pwrite;
    // register kind of the address on the bus
    assign acc_kind = reg_of(apb_req.paddr);

    // one setpoint word per timer, each with its own write decode
    generate
        for (genvar g = 0; g < NT; g++) begin : g_word
            always_comb begin
                tmr_d[g] = tmr_q[g];
                if (wr_setup && timer_idx(apb_req.paddr) == g) begin
                    tmr_d[g] = merge(tmr_q[g], apb_req.pwdata,
                                     apb_req.pstrb);
                end
            end

            // setpoints fall back to the stored defaults on reset
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    tmr_q[g] <= wct_pkg::TIMER_RST;
                end else begin
                    tmr_q[g] <= tmr_d[g];
                end
            end
        end
    endgenerate

    // routing word: unused bits never stored, so they read back 0
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_setup && acc_kind == REG_CTRL) begin
            ctrl_d = merge(ctrl_q, apb_req.pwdata, apb_req.pstrb);
            ctrl_d[wct_pkg::DATA_W-1:wct_pkg::F_DISC_MAP+1] = '0;
        end
    end

    // routing falls back to the standard configuration on reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= wct_pkg::CTRL_RST;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // ------------------------------------------------------------------
    // read-only status words
    // ------------------------------------------------------------------

    // live status, status codes and clock reading for the read mux
    always_comb begin
        stat_w = '0;
        stat_w[wct_pkg::F_ST_ACT +: NT] = act;
        stat_w[wct_pkg::F_ST_OUT1] = out1_q;
        stat_w[wct_pkg::F_ST_OUT2] = out2_q;
        codes_w = '0;
        codes_w[CODE_W*NT-1:0] = all_codes;
        time_w = '0;
        time_w[wct_pkg::F_T_MIN +: wct_pkg::MIN_W] = rtc_minute;
        time_w[wct_pkg::F_T_DAY +: wct_pkg::DAY_W] = rtc_weekday;
    end

    // ------------------------------------------------------------------
    // apb read data and error
    // ------------------------------------------------------------------

    // read word and error prepared in setup, shown during access
    always_comb begin
        prdata_d = prdata_q;
        pslverr_d = pslverr_q;
        if (setup) begin
            prdata_d = '0;
            pslverr_d = 1'b0;
            if (acc_kind == REG_TIMER) begin
                prdata_d = tmr_q[timer_idx(apb_req.paddr)];
                prdata_d[wct_pkg::DATA_W-1] = 1'b0;
            end else if (acc_kind == REG_CTRL) begin
                prdata_d = ctrl_q;
            end else if (acc_kind == REG_STAT) begin
                prdata_d = stat_w;
            end else if (acc_kind == REG_CODES) begin
                prdata_d = codes_w;
            end else if (acc_kind == REG_TIME) begin
                prdata_d = time_w;
            end else begin
                pslverr_d = 1'b1; // unmapped address
            end
        end
    end

    // read word held until the next setup cycle
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // zero wait states; data and error valid only with penable
    assign pready = 1'b1;
    assign prdata = (apb_req.psel && apb_req.penable
                     && !apb_req.pwrite) ? prdata_q : '0;
    assign pslverr = apb_req.psel && apb_req.penable && pslverr_q;

endmodule

// ==== verification/wct_load_model.sv ====
// far-side model: engine run logic and discrete output relay
`timescale 1ns/1ps
module wct_load_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic run_req,
    input wire logic relay_cmd,
    output logic engine_run,
    output logic relay_on
);
    logic run_d, run_q, relay_d, relay_q;
    // engine in auto follows the run request, relay its command
    always_comb begin
        run_d = run_req;
        relay_d = relay_cmd;
    end
    // one cycle of pick-up delay on both
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            run_q <= 1'b0;
            relay_q <= 1'b0;
        end else begin
            run_q <= run_d;
            relay_q <= relay_d;
        end
    end
    assign engine_run = run_q;
    assign relay_on = relay_q;
endmodule

// ==== verification/wct_top_sva.sv ====
// port assertions for the weekly cycle timer scheduler
`timescale 1ns/1ps
module wct_top_sva (
    input wire logic clk,
    input wire logic arst_n,
    input wct_pkg::wct_apb_req_s apb_req,
    input wire logic pready,
    input wire logic [wct_pkg::DATA_W-1:0] prdata,
    input wire logic pslverr,
    input wire logic [wct_pkg::MIN_W-1:0] rtc_minute,
    input wire logic run_request_output,
    input wire logic aux_request_output,
    input wire logic remote_run_req,
    input wire logic discrete_out,
    input wire logic [wct_pkg::NUM_TIMERS-1:0] timer_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic rd_acc;
    // read access phase
    assign rd_acc = apb_req.psel & apb_req.penable & ~apb_req.pwrite;
    // minute moved in the previous cycle
    sequence s_moved;
        $past(rtc_minute) != $past(rtc_minute, 2);
    endsequence
    a_pready_high: assert property (pready)
        else $error("pready low");
    a_prdata_gate: assert property (!rd_acc |-> prdata == 32'h0)
        else $error("prdata outside read access");
    a_slverr_gate: assert property (
        pslverr |-> apb_req.psel && apb_req.penable)
        else $error("pslverr outside access");
    a_run_source: assert property (
        run_request_output |-> $past(|timer_active))
        else $error("run output without active timer");
    a_aux_source: assert property (
        aux_request_output |-> $past(|timer_active))
        else $error("aux output without active timer");
    a_remote_route: assert property (
        remote_run_req |-> run_request_output)
        else $error("remote run without run output");
    a_remote_fall: assert property (
        $fell(run_request_output) |-> !remote_run_req)
        else $error("remote run outlived run output");
    a_disc_route: assert property (
        discrete_out |-> aux_request_output)
        else $error("discrete output without aux output");
    a_tick_change: assert property (
        $changed(timer_active) |-> s_moved)
        else $error("timer changed without minute tick");
endmodule

// ==== verification/wct_top_tb.sv ====
// self-checking bench for the weekly cycle timer scheduler
`timescale 1ns/1ps
module wct_top_tb;
    logic clk, arst_n, pready, pslverr, err, run_o, aux_o, rem_o, disc_o;
    logic eng, rly;
    wct_pkg::wct_apb_req_s req;
    logic [31:0] prdata, rd;
    logic [2:0] day;
    logic [10:0] mnt;
    logic [6:0] act;
    int bad_count, cmp_count;

    wct_top DUT (.clk(clk), .arst_n(arst_n), .apb_req(req),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .rtc_weekday(day), .rtc_minute(mnt), .run_request_output(run_o),
        .aux_request_output(aux_o), .remote_run_req(rem_o),
        .discrete_out(disc_o), .timer_active(act));
    wct_load_model u_load (.clk(clk), .arst_n(arst_n), .run_req(rem_o),
        .relay_cmd(disc_o), .engine_run(eng), .relay_on(rly));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        @(posedge clk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= a;
        req.pwdata <= wd;
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    // new clock reading, then let outputs and relay settle
    task automatic set_time(input logic [2:0] d, input logic [10:0] m);
        @(posedge clk);
        day <= d;
        mnt <= m;
        repeat (5) @(posedge clk);
    endtask

    function automatic logic [31:0] word(input logic [6:0] dy,
        input logic o1, input logic o2, input logic [4:0] sh,
        input logic [5:0] sm, input logic [4:0] dh, input logic [5:0] dm);
        logic [31:0] w;
        w = {1'b0, dm, dh, sm, sh, o2, o1, dy};
        return w;
    endfunction

    task automatic t_reset;
        apb(1'b0, wct_pkg::OFS_CTRL, 32'h0);
        chk(rd, 32'h0000_0001);
        apb(1'b0, 12'h018, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, wct_pkg::OFS_CODES, 32'h0);
        chk(rd, 32'h0aaa_aaaa);
    endtask

    task automatic t_access;
        apb(1'b1, 12'h030, 32'hffff_ffff);
        chk(32'(err), 32'h1);
        apb(1'b1, wct_pkg::OFS_STAT, 32'hffff_ffff);
        apb(1'b0, wct_pkg::OFS_STAT, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, wct_pkg::OFS_CTRL, 32'hffff_ffff);
        apb(1'b0, wct_pkg::OFS_CTRL, 32'h0);
        chk(rd, 32'h0000_0003);
        apb(1'b1, wct_pkg::OFS_CTRL, 32'h1);
    endtask

    task automatic t_run;
        apb(1'b1, wct_pkg::OFS_TIMER0,
            word(7'h02, 1'b1, 1'b0, 5'h01, 6'h00, 5'h00, 6'h02));
        set_time(3'h1, 11'h03b);
        chk(32'(act), 32'h0);
        set_time(3'h1, 11'h03c);
        chk(32'({act, run_o, rem_o, eng}), 32'h0f);
        apb(1'b0, wct_pkg::OFS_STAT, 32'h0);
        chk(rd, 32'h0000_0101);
        apb(1'b0, wct_pkg::OFS_TIME, 32'h0);
        chk(rd, 32'h0001_003c);
        apb(1'b0, wct_pkg::OFS_CODES, 32'h0);
        chk(rd, 32'h0aaa_aaa9);
        set_time(3'h1, 11'h03d);
        chk(32'(act), 32'h1);
        set_time(3'h1, 11'h03e);
        chk(32'({act, run_o, rem_o}), 32'h0);
        apb(1'b0, wct_pkg::OFS_CODES, 32'h0);
        chk(rd, 32'h0aaa_aaa8);
        set_time(3'h2, 11'h03b);
        set_time(3'h2, 11'h03c);
        chk(32'(act), 32'h0);
    endtask

    task automatic t_aux;
        apb(1'b1, wct_pkg::OFS_CTRL, 32'h3);
        apb(1'b1, 12'h018,
            word(7'h08, 1'b0, 1'b1, 5'h17, 6'h3b, 5'h00, 6'h02));
        set_time(3'h3, 11'h59e);
        apb(1'b0, wct_pkg::OFS_CODES, 32'h0);
        chk(rd, 32'h02aa_aaa8);
        set_time(3'h3, 11'h59f);
        chk(32'({act, aux_o, run_o, disc_o, rly}), 32'h40b);
        apb(1'b0, wct_pkg::OFS_CODES, 32'h0);
        chk(rd, 32'h06aa_aaa8);
        apb(1'b1, wct_pkg::OFS_CTRL, 32'h1);
        apb(1'b0, wct_pkg::OFS_STAT, 32'h0);
        chk(rd, 32'h0000_0240);
        chk(32'({aux_o, disc_o}), 32'h2);
        set_time(3'h4, 11'h000);
        chk(32'({act, aux_o}), 32'h81);
        set_time(3'h4, 11'h001);
        chk(32'({act, aux_o, disc_o}), 32'h0);
    endtask

    task automatic test_done;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // watchdog against a hung bench
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        test_done();
    end

    initial begin
        req = '0;
        req.pstrb = 4'hf;
        day = 3'h0;
        mnt = 11'h000;
        arst_n = 1'b0;
        bad_count = 0;
        cmp_count = 0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_access();
        t_run();
        t_aux();
        test_done();
    end
endmodule

bind wct_top wct_top_sva u_sva (.clk(clk), .arst_n(arst_n),
    .apb_req(apb_req), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .rtc_minute(rtc_minute),
    .run_request_output(run_request_output),
    .aux_request_output(aux_request_output),
    .remote_run_req(remote_run_req), .discrete_out(discrete_out),
    .timer_active(timer_active));
